// [common/rmc_defs.svh]
// constants of the robot motion command frame handler
`ifndef RMC_DEFS_SVH
`define RMC_DEFS_SVH
`define RMC_TYPE_CMD 8'h10
`define RMC_TYPE_ACK 8'h7f
`define RMC_MODEM_ADDR 8'hff
`define RMC_CODE_CTRL 16'h1000
`define RMC_CODE_STOP 16'h0403
`define RMC_ACCESS 16'h0001
`define RMC_LEN_CTRL 8'h10
`define RMC_LEN_STOP 8'h04
`define RMC_LEN_OFS 5'h06
`define RMC_PAY_OFS 5'h07
`define RMC_CRC_INIT 16'hffff
`define RMC_CRC_POLY 16'ha001
`define RMC_REPLY_LAST 4'hf
`define RMC_CLK_NS 25
`define RMC_GAP_NS 1000000
`define RMC_GAP_CYC (`RMC_GAP_NS / `RMC_CLK_NS)
`define RMC_REG_CFG 8'h00
`define RMC_REG_STAT 8'h04
`define RMC_REG_CMD 8'h08
`define RMC_REG_BAD 8'h0c
`define RMC_CFG_ADDR_RST 8'h01
`define RMC_CFG_EN_RST 1'b1
`define RMC_CFG_EN_BIT 8
`endif

// [common/rmc_pkg.sv]
// types of the robot motion command frame handler
package rmc_pkg;
  typedef enum logic [2:0] {
    RMC_M_WAIT, RMC_M_POWER, RMC_M_SPEED, RMC_M_PROG, RMC_M_PAUSE, RMC_M_RESUME
  } rmc_mode_t;
  typedef enum logic [2:0] {
    RMC_OP_FWD, RMC_OP_BACK, RMC_OP_CW, RMC_OP_CCW,
    RMC_OP_WAIT, RMC_OP_LOOP, RMC_OP_GOTO, RMC_OP_SPEED
  } rmc_op_t;
  typedef enum logic [1:0] {RMC_X_IDLE, RMC_X_MANUAL, RMC_X_ISSUE, RMC_X_WAIT} rmc_exec_t;
  typedef struct packed {
    rmc_op_t op;
    logic [15:0] p1;
    logic [15:0] y;
    logic [15:0] z;
  } rmc_step_t;
  typedef struct packed {
    logic active;
    logic speed_mode;
    rmc_op_t op;
    logic [7:0] level;
  } rmc_drive_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] code;
  } rmc_reply_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rmc_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rmc_apb_rsp_t;
  typedef struct packed {
    logic [15:0] crc;
  } rmc_crc_st_t;
  typedef struct packed {
    logic busy;
    logic [3:0] idx;
    logic [3:0] cur;
    rmc_reply_t rep;
    logic valid;
    logic [7:0] data;
  } rmc_tx_st_t;
  typedef struct packed {
    logic [4:0] idx;
    logic drop;
    logic [15:0] gap;
    logic chk;
    logic [7:0] addr;
    logic [7:0] typ;
    logic [15:0] code;
    logic [15:0] acc;
    logic [7:0] len;
    logic [7:0] mode;
    logic [7:0] op;
    logic [7:0] b2;
    logic [15:0] p1;
    logic [7:0] b5;
    logic [15:0] y;
    logic [15:0] z;
    rmc_exec_t ex;
    logic paused;
    logic [7:0] pc;
    logic [7:0] total;
    logic [8:0] cnt;
    rmc_drive_t drive;
    rmc_step_t step;
    logic step_go;
    logic stop;
    logic rep_go;
    rmc_reply_t rep;
    logic [23:0] cmd;
    logic [7:0] cfg_addr;
    logic cfg_en;
    logic [15:0] bad;
    rmc_apb_rsp_t apb;
  } rmc_core_st_t;
endpackage

// [core/rmc_crc16.sv]
// byte-serial crc-16 register with synchronous restart
`timescale 1ns/100ps
`include "rmc_defs.svh"
module rmc_crc16 (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic i_vld,
  input wire logic [7:0] i_byte,
  output logic [15:0] o_crc
);
  import rmc_pkg::*;
  rmc_crc_st_t q, d;

  function automatic logic [15:0] rmc_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RMC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_comb begin
    d = q;
    if (i_clr) d.crc = `RMC_CRC_INIT;
    if (i_vld) d.crc = rmc_crc_byte(i_clr ? `RMC_CRC_INIT : q.crc, i_byte);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) q <= '{crc: `RMC_CRC_INIT};
    else q <= d;
  end

  assign o_crc = q.crc;
endmodule // rmc_crc16

// [core/rmc_reply_tx.sv]
// sends the sixteen-byte acknowledge and echo reply as a byte stream
`timescale 1ns/100ps
`include "rmc_defs.svh"
module rmc_reply_tx (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input rmc_pkg::rmc_reply_t i_rep,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_busy
);
  import rmc_pkg::*;
  rmc_tx_st_t q, d;
  logic ld;
  logic [15:0] crc;

  // bytes 0..7 are the modem part, 8..15 the robot echo; same layout
  function automatic logic [7:0] rmc_rbyte(input logic [3:0] i, input rmc_reply_t r,
                                           input logic [15:0] c);
    case (i[2:0])
      3'h0: return i[3] ? r.addr : `RMC_MODEM_ADDR; // [R3] [R4]
      3'h1: return i[3] ? `RMC_TYPE_CMD : `RMC_TYPE_ACK; // [R3] [R4]
      3'h2: return r.code[7:0];
      3'h3: return r.code[15:8];
      3'h6: return c[7:0];
      3'h7: return c[15:8];
      default: return 8'h00;
    endcase
  endfunction

  assign ld = q.busy && (!q.valid || i_ready);

  always_comb begin
    d = q;
    if (q.valid && i_ready) d.valid = 1'b0;
    if (ld) begin
      d.valid = 1'b1;
      d.data = rmc_rbyte(q.idx, q.rep, crc);
      d.cur = q.idx;
      d.idx = q.idx + 4'h1;
      if (q.idx == `RMC_REPLY_LAST) d.busy = 1'b0;
    end
    if (i_go && !q.busy) begin
      d.busy = 1'b1;
      d.idx = 4'h0;
      d.rep = i_rep;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) q <= '0;
    else q <= d;
  end

  // each half restarts the crc and covers its own first six bytes
  rmc_crc16 u_crc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clr(ld && q.idx[2:0] == 3'h0), // [R3] [R4]
    .i_vld(ld && q.idx[2:0] < 3'h6),
    .i_byte(rmc_rbyte(q.idx, q.rep, crc)),
    .o_crc(crc)
  );

  assign o_valid = q.valid;
  assign o_data = q.data;
  assign o_busy = q.busy;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_ack_header: assert property (q.valid && q.cur == 4'h1 |-> q.data == 8'h7f) // [R3]
    else $error("ack type byte wrong");
  chk_echo_header: assert property (q.valid && q.cur == 4'h9 |-> q.data == 8'h10) // [R4]
    else $error("echo type byte wrong");
  chk_echo_code: assert property (q.valid && q.cur == 4'ha |-> q.data == q.rep.code[7:0]) // [R4]
    else $error("echo code low byte wrong");
endmodule // rmc_reply_tx

// [core/rmc_core.sv]
// robot motion command frame handler: parser, program store, sequencer, apb
// Summary of operation
// R1: request header address, type, code, access
// R2: length 0x10, sixteen payload bytes, crc
// R3: reply starts with modem acknowledge eight bytes
// R4: robot echo follows at reply byte eight
// R5: payload byte 0 picks control mode
// R6: payload byte 1 picks the operation
// R7: byte 2 is power, speed or index
// R8: bytes 3-4 carry the step parameter
// R9: byte 5 gives total program steps
// R10: bytes 6-9 carry target y and z
// R11: mode 1 drives at commanded power
// R12: mode 2 holds the commanded speed
// R13: mode 4 pauses, mode 5 resumes program
// R14: host sends one frame per step
// R15: run after all steps, halt after last
// R16: loop operation repeats until stop, upload or a mode 1 or 2 drive frame
// R17: stop request header and length 0x04
// R18: stop aborts motion and waits idle
// R19: bad crc frame is dropped, state kept
// R20: host zeroes reserved payload bytes
`timescale 1ns/100ps
`include "rmc_defs.svh"
module rmc_core #(
  parameter int GAP_CYC = `RMC_GAP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input rmc_pkg::rmc_apb_req_t i_apb,
  output rmc_pkg::rmc_apb_rsp_t o_apb,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output rmc_pkg::rmc_drive_t o_drive,
  output rmc_pkg::rmc_step_t o_step,
  output logic o_step_go,
  input wire logic i_step_done,
  output logic o_hold,
  output logic o_stop
);
  import rmc_pkg::*;
  rmc_core_st_t q, d;
  rmc_step_t mem [256];
  rmc_step_t cur;
  logic mem_we;
  logic [7:0] mem_wa;
  rmc_step_t mem_wd;
  logic [15:0] rx_crc;
  logic tx_busy;
  logic hdr_ok, is_ctrl, is_stop, good_w, bad_w;

  function automatic logic rmc_reg_hit(input logic [7:0] a);
    return a == `RMC_REG_CFG || a == `RMC_REG_STAT || a == `RMC_REG_CMD || a == `RMC_REG_BAD;
  endfunction

  assign cur = mem[q.pc];
  assign hdr_ok = q.typ == `RMC_TYPE_CMD && q.acc == `RMC_ACCESS && q.cfg_en
                  && q.addr == q.cfg_addr; // [R1]
  assign is_ctrl = q.code == `RMC_CODE_CTRL && q.len == `RMC_LEN_CTRL; // [R2]
  assign is_stop = q.code == `RMC_CODE_STOP && q.len == `RMC_LEN_STOP; // [R17]
  assign good_w = q.chk && hdr_ok && (is_ctrl || is_stop) && rx_crc == 16'h0000;
  assign bad_w = q.chk && hdr_ok && (is_ctrl || is_stop) && rx_crc != 16'h0000; // [R19]

  always_comb begin
    logic [8:0] nc;
    nc = (q.b2 == 8'h00) ? 9'h001 : q.cnt + 9'h001;
    d = q;
    d.step_go = 1'b0;
    d.stop = 1'b0;
    d.rep_go = 1'b0;
    d.chk = 1'b0;
    mem_we = 1'b0;
    mem_wa = q.b2;
    mem_wd = '{op: rmc_op_t'(q.op[2:0]), p1: q.p1, y: q.y, z: q.z}; // [R8] [R10]

    // frame receiver: fields are captured by their byte position
    if (i_rx_valid) begin
      d.gap = 16'h0000;
      if (!q.drop) begin
        case (q.idx)
          5'h00: d.addr = i_rx_data;
          5'h01: d.typ = i_rx_data;
          5'h02: d.code[7:0] = i_rx_data;
          5'h03: d.code[15:8] = i_rx_data;
          5'h04: d.acc[7:0] = i_rx_data;
          5'h05: d.acc[15:8] = i_rx_data;
          5'h06: d.len = i_rx_data;
          5'h07: d.mode = i_rx_data; // [R5]
          5'h08: d.op = i_rx_data; // [R6]
          5'h09: d.b2 = i_rx_data; // [R7]
          5'h0a: d.p1[7:0] = i_rx_data; // [R8]
          5'h0b: d.p1[15:8] = i_rx_data;
          5'h0c: d.b5 = i_rx_data; // [R9]
          5'h0d: d.y[7:0] = i_rx_data; // [R10]
          5'h0e: d.y[15:8] = i_rx_data;
          5'h0f: d.z[7:0] = i_rx_data;
          5'h10: d.z[15:8] = i_rx_data;
          default: ;
        endcase
        if (q.idx == `RMC_LEN_OFS && i_rx_data != `RMC_LEN_CTRL
            && i_rx_data != `RMC_LEN_STOP) begin
          d.drop = 1'b1;
        end else if (q.idx >= `RMC_PAY_OFS && q.idx == 5'(q.len + 8'h08)) begin
          d.idx = 5'h00;
          d.chk = 1'b1; // [R2]
        end else begin
          d.idx = q.idx + 5'h01;
        end
      end
    end else if (q.idx != 5'h00 || q.drop) begin
      // a silent line ends any partial frame
      d.gap = q.gap + 16'h0001;
      if (q.gap >= 16'(GAP_CYC - 1)) begin
        d.idx = 5'h00;
        d.drop = 1'b0;
        d.gap = 16'h0000;
      end
    end

    // program sequencer
    case (q.ex)
      RMC_X_ISSUE: begin
        if (!q.paused) begin // [R13]
          if (cur.op == RMC_OP_LOOP) begin
            d.pc = 8'h00; // [R16]
          end else begin
            d.step = cur;
            d.step_go = 1'b1;
            d.ex = RMC_X_WAIT;
          end
        end
      end
      RMC_X_WAIT: begin
        if (i_step_done) begin
          if (q.pc == q.total - 8'h01) begin
            d.ex = RMC_X_IDLE; // [R15]
          end else begin
            d.pc = q.pc + 8'h01;
            d.ex = RMC_X_ISSUE;
          end
        end
      end
      default: ;
    endcase

    // a good frame overrides the sequencer in the same cycle
    if (bad_w) d.bad = q.bad + 16'h0001; // [R19]
    if (good_w) begin
      d.rep_go = !tx_busy; // [R3] [R4]
      d.rep = '{addr: q.addr, code: q.code};
      if (is_stop) begin
        d.ex = RMC_X_IDLE; // [R18]
        d.paused = 1'b0;
        d.drive.active = 1'b0;
        d.step_go = 1'b0;
        d.stop = 1'b1;
      end else begin
        d.cmd = {q.mode, q.op, q.b2};
        case (q.mode) // [R5]
          8'h00: begin
            d.drive.active = 1'b0;
            if (q.ex == RMC_X_MANUAL) d.ex = RMC_X_IDLE;
          end
          8'h01, 8'h02: begin
            if (q.op < 8'h04) begin // [R6]
              d.drive.active = 1'b1; // [R11]
              d.drive.speed_mode = q.mode == 8'h02; // [R12]
              d.drive.op = rmc_op_t'(q.op[2:0]);
              d.drive.level = q.b2; // [R7]
              d.ex = RMC_X_MANUAL;
              d.paused = 1'b0;
              d.step_go = 1'b0;
            end
          end
          8'h03: begin
            if (q.b2 < q.b5) begin // [R14]
              mem_we = 1'b1;
              d.total = q.b5; // [R9]
              d.cnt = nc;
              d.ex = RMC_X_IDLE; // [R16]
              d.paused = 1'b0;
              d.step_go = 1'b0;
              d.drive.active = 1'b0;
              if (nc == {1'b0, q.b5}) begin
                d.pc = 8'h00;
                d.ex = RMC_X_ISSUE; // [R15]
              end
            end
          end
          8'h04: begin
            if (q.ex == RMC_X_ISSUE || q.ex == RMC_X_WAIT) d.paused = 1'b1; // [R13]
          end
          8'h05: d.paused = 1'b0; // [R13]
          default: ;
        endcase
      end
    end

    // apb slave: one wait state, answer registered
    d.apb.pready = i_apb.psel && i_apb.penable && !q.apb.pready;
    if (d.apb.pready) begin
      d.apb.pslverr = !rmc_reg_hit(i_apb.paddr);
      case (i_apb.paddr)
        `RMC_REG_CFG: d.apb.prdata = {23'h000000, q.cfg_en, q.cfg_addr};
        `RMC_REG_STAT: d.apb.prdata = {5'h00, q.paused, q.ex, q.total, q.pc, q.cnt[7:0]};
        `RMC_REG_CMD: d.apb.prdata = {8'h00, q.cmd};
        `RMC_REG_BAD: d.apb.prdata = {16'h0000, q.bad};
        default: d.apb.prdata = 32'h00000000;
      endcase
    end else begin
      d.apb.pslverr = 1'b0;
      d.apb.prdata = 32'h00000000;
    end
    if (i_apb.psel && i_apb.penable && q.apb.pready && i_apb.pwrite
        && i_apb.paddr == `RMC_REG_CFG) begin
      d.cfg_addr = i_apb.pwdata[7:0];
      d.cfg_en = i_apb.pwdata[`RMC_CFG_EN_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.cfg_addr <= `RMC_CFG_ADDR_RST;
      q.cfg_en <= `RMC_CFG_EN_RST;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  // the residue over data plus appended crc is zero for an intact frame
  rmc_crc16 u_rx_crc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clr(q.idx == 5'h00),
    .i_vld(i_rx_valid && !q.drop),
    .i_byte(i_rx_data),
    .o_crc(rx_crc)
  );

  rmc_reply_tx u_tx (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_go(q.rep_go),
    .i_rep(q.rep),
    .i_ready(i_tx_ready),
    .o_valid(o_tx_valid),
    .o_data(o_tx_data),
    .o_busy(tx_busy)
  );

  assign o_apb = q.apb;
  assign o_drive = q.drive;
  assign o_step = q.step;
  assign o_step_go = q.step_go;
  assign o_hold = q.paused;
  assign o_stop = q.stop;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_stop_idle: assert property (good_w && is_stop // [R18]
      |=> q.ex == RMC_X_IDLE && !q.drive.active && q.stop ##1 !q.stop)
    else $error("stop did not idle the robot");
  // the sequencer may still advance on its own while a bad frame is dropped
  chk_bad_frame: assert property (bad_w // [R19]
      |=> $stable(q.drive) && $stable(q.paused) && $stable(q.cmd) && $stable(q.total)
      && ($stable(q.ex) || $past(q.ex) == RMC_X_ISSUE || $past(q.ex) == RMC_X_WAIT)
      && q.bad == $past(q.bad) + 16'h0001)
    else $error("bad frame changed state");
  chk_power_drive: assert property (good_w && is_ctrl && q.mode == 8'h01 // [R11]
      && q.op < 8'h04 |=> q.drive.active && !q.drive.speed_mode
      && q.drive.level == $past(q.b2))
    else $error("power mode not applied");
  chk_speed_drive: assert property (good_w && is_ctrl && q.mode == 8'h02 // [R12]
      && q.op < 8'h04 |=> q.drive.active && q.drive.speed_mode && q.ex == RMC_X_MANUAL)
    else $error("speed mode not applied");
  chk_op_range: assert property (good_w && is_ctrl && q.op > 8'h03 // [R6]
      && (q.mode == 8'h01 || q.mode == 8'h02) |=> $stable(q.drive))
    else $error("out of range operation moved the drive");
  chk_prog_total: assert property (good_w && is_ctrl && q.mode == 8'h03 // [R9]
      && q.b2 < q.b5 |=> q.total == $past(q.b5))
    else $error("program length not taken");
  chk_pause_freeze: assert property (q.paused && q.ex == RMC_X_ISSUE && !q.chk // [R13]
      |=> !q.step_go)
    else $error("step issued while paused");
  chk_run_loaded: assert property (q.step_go |-> q.cnt == {1'b0, q.total}) // [R15]
    else $error("program ran before fully loaded");
  chk_halt_last: assert property (q.ex == RMC_X_WAIT && i_step_done // [R15]
      && q.pc == q.total - 8'h01 && !q.chk |=> q.ex == RMC_X_IDLE)
    else $error("program did not halt after last step");
  chk_loop_restart: assert property (q.ex == RMC_X_ISSUE && !q.paused // [R16]
      && cur.op == RMC_OP_LOOP && !q.chk |=> q.pc == 8'h00 && q.ex == RMC_X_ISSUE)
    else $error("loop step did not restart");
  chk_reply_go: assert property (good_w && !tx_busy |=> q.rep_go ##1 tx_busy) // [R3]
    else $error("reply not started");
endmodule // rmc_core

// [tb/rmc_host_model.sv]
// host model: sends command frames byte by byte and drains the reply stream
`timescale 1ns/100ps
module rmc_host_model (
  input wire logic i_clk,
  input wire logic i_stall,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_tx_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data
);
  logic [7:0] rep_q[$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h5a;
    o_tx_ready = 1'b0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // pay holds control bytes 0..9, lowest byte first; bad corrupts the crc
  task automatic send(input logic [7:0] addr, input logic stp, input logic [79:0] pay,
                      input logic bad);
    logic [7:0] f[$];
    logic [15:0] c;
    f = {addr, 8'h10, stp ? 8'h03 : 8'h00, stp ? 8'h04 : 8'h10, 8'h01, 8'h00};
    f.push_back(stp ? 8'h04 : 8'h10);
    for (int i = 0; i < (stp ? 4 : 16); i++) begin
      f.push_back(i < 10 ? pay[i*8 +: 8] : 8'h00);
    end
    c = crc16(f);
    if (bad) c = ~c;
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_data <= f[i];
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~f[f.size()-1];
  endtask
  // ready toggles while stalling, so each reply byte must be held until taken
  always @(posedge i_clk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) rep_q.push_back(i_tx_data);
    o_tx_ready <= i_stall ? ~o_tx_ready : 1'b1;
  end
endmodule // rmc_host_model

// [tb/robot_motion_command_frames_tb.sv]
// self-checking bench for the robot motion command frame handler
`timescale 1ns/100ps
module robot_motion_command_frames_tb;
  import rmc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  rmc_apb_req_t apb_q = '0;
  rmc_apb_rsp_t apb_rsp;
  logic rx_valid, tx_ready, tx_valid, step_go, hold, stop;
  logic stall = 1'b0;
  logic [7:0] rx_data, tx_data;
  rmc_drive_t drive;
  rmc_step_t step;
  logic step_done = 1'b0;
  logic [4:0] done_sr = '0;
  rmc_step_t steps_q[$];
  int stops = 0;
  int err_count = 0;
  int check_count = 0;
  int n;
  logic [31:0] rd;
  logic err;
  // {level, op, mode} beside the expected drive {active, speed, op, level}
  logic [36:0] rows[8] = '{{24'h320001, 13'h1032}, {24'h000101, 13'h1100},
    {24'h640202, 13'h1a64}, {24'h010302, 13'h1b01}, {24'h100401, 13'h1b01},
    {24'hff0002, 13'h18ff}, {24'h7f0201, 13'h127f}, {24'h050102, 13'h1905}};
  always #12.5 i_clk = ~i_clk;
  rmc_core #(.GAP_CYC(50)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_apb(apb_q),
    .o_apb(apb_rsp), .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_tx_ready(tx_ready),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_drive(drive), .o_step(step),
    .o_step_go(step_go), .i_step_done(step_done), .o_hold(hold), .o_stop(stop));
  rmc_host_model i_host (.i_clk(i_clk), .i_stall(stall), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .o_tx_ready(tx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data));
  // motion logic stand-in: logs issued steps, reports each done six cycles later
  always @(posedge i_clk) begin
    if (step_go === 1'b1) steps_q.push_back(step);
    if (stop === 1'b1) stops++;
    done_sr <= {done_sr[3:0], step_go === 1'b1};
    step_done <= done_sr[4];
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    @(posedge i_clk);
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge i_clk);
    apb_q.penable <= 1'b1;
    // no cycle count assumed here: only the watchdog ends a stuck wait
    do begin
      @(posedge i_clk);
    end while (apb_rsp.pready !== 1'b1);
    d = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_q <= '0;
  endtask
  task automatic check_reply(input logic [15:0] code);
    logic [7:0] h[$];
    logic [7:0] r[$];
    logic [15:0] ch, cr;
    int w;
    h = {8'hff, 8'h7f, code[7:0], code[15:8], 8'h00, 8'h00};
    r = {8'h01, 8'h10, code[7:0], code[15:8], 8'h00, 8'h00};
    ch = i_host.crc16(h);
    cr = i_host.crc16(r);
    h = {h, ch[7:0], ch[15:8], r, cr[7:0], cr[15:8]};
    w = 0;
    while (i_host.rep_q.size() < 16 && w < 400) begin
      @(posedge i_clk);
      w++;
    end
    check(i_host.rep_q.size(), 16);
    foreach (h[i]) check(i_host.rep_q[i], h[i]);
    i_host.rep_q.delete();
  endtask
  task automatic prog(input logic [7:0] idx, input rmc_op_t op, input logic [15:0] p1,
                      input logic [7:0] tot, input logic [31:0] zy);
    i_host.send(8'h01, 1'b0, {zy, tot, p1, idx, 5'h00, op, 8'h03}, 1'b0);
    check_reply(16'h1000);
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    check({drive, tx_valid, step_go, hold, stop, apb_rsp}, '0);
    i_rst_n <= 1'b1;
    apb(1'b0, 8'h00, '0, rd, err);
    check(rd, 32'h0000_0101);
    apb(1'b0, 8'h10, '0, rd, err);
    check(err, 1'b1);
    foreach (rows[i]) begin
      stall <= i[0];
      i_host.send(8'h01, 1'b0, {56'h0, rows[i][36:13]}, 1'b0);
      check_reply(16'h1000);
      check(drive, rows[i][12:0]);
    end
    apb(1'b0, 8'h08, '0, rd, err);
    check(rd, 32'h0002_0105);
    i_host.send(8'h01, 1'b0, 80'h0, 1'b0);
    check_reply(16'h1000);
    check(drive.active, 1'b0);
    i_host.send(8'h01, 1'b0, 80'h400001, 1'b1);
    i_host.send(8'h02, 1'b0, 80'h400001, 1'b0);
    idle(60);
    check(i_host.rep_q.size(), 0);
    check(drive.active, 1'b0);
    apb(1'b0, 8'h0c, '0, rd, err);
    check(rd[15:0], 16'h0001);
    prog(8'h00, RMC_OP_FWD, 16'h0123, 8'h03, 32'h0);
    prog(8'h01, RMC_OP_GOTO, 16'hfffb, 8'h03, 32'hfe00_0200);
    check(steps_q.size(), 0);
    prog(8'h02, RMC_OP_WAIT, 16'h000a, 8'h03, 32'h0);
    idle(60);
    check(steps_q.size(), 3);
    check(steps_q[0], {RMC_OP_FWD, 16'h0123, 32'h0});
    check(steps_q[1], {RMC_OP_GOTO, 16'hfffb, 16'h0200, 16'hfe00});
    check(steps_q[2], {RMC_OP_WAIT, 16'h000a, 32'h0});
    apb(1'b0, 8'h04, '0, rd, err);
    check(rd[25:24], 2'h0);
    steps_q.delete();
    prog(8'h00, RMC_OP_CW, 16'h005a, 8'h02, 32'h0);
    prog(8'h01, RMC_OP_LOOP, 16'h0000, 8'h02, 32'h0);
    idle(100);
    check(steps_q.size() > 4, 1'b1);
    check(steps_q[$].op, RMC_OP_CW);
    i_host.send(8'h01, 1'b0, 80'h04, 1'b0);
    check_reply(16'h1000);
    check(hold, 1'b1);
    n = steps_q.size();
    idle(60);
    check(steps_q.size(), n);
    i_host.send(8'h01, 1'b0, 80'h05, 1'b0);
    check_reply(16'h1000);
    idle(60);
    check({hold, steps_q.size() > n}, 2'h1);
    i_host.send(8'h01, 1'b1, 80'h0, 1'b0);
    check_reply(16'h0403);
    n = steps_q.size();
    idle(60);
    check(stops, 1);
    check(steps_q.size(), n);
    apb(1'b0, 8'h04, '0, rd, err);
    check(rd[26:24], 3'h0);
    // other address, accept disabled: a good frame must be ignored
    apb(1'b1, 8'h00, 32'h0000_0002, rd, err);
    apb(1'b0, 8'h00, '0, rd, err);
    check(rd, 32'h0000_0002);
    i_host.send(8'h01, 1'b0, 80'h400001, 1'b0);
    idle(60);
    check({i_host.rep_q.size(), drive.active}, 33'h0);
    // reset in mid-run restores the configuration defaults
    i_rst_n <= 1'b0;
    idle(2);
    check({drive, tx_valid, step_go, hold, stop, apb_rsp}, '0);
    i_rst_n <= 1'b1;
    apb(1'b0, 8'h00, '0, rd, err);
    check(rd, 32'h0000_0101);
    wrap_up();
  end
endmodule // robot_motion_command_frames_tb
